// ---- include/uee_pkg.sv ----
// Register map, field layout and shared types of the USB interrupt gate block
package uee_pkg;

   // ***********************************************************
   // Register offsets
   // ***********************************************************
   localparam int unsigned ADDR_W = 12;

   localparam logic [ADDR_W-1:0] OFS_STAT_EN    = 12'hf36;
   localparam logic [ADDR_W-1:0] OFS_ERR_EN     = 12'hf37;
   localparam logic [ADDR_W-1:0] OFS_STAT_CLR   = 12'hf38;
   localparam logic [ADDR_W-1:0] OFS_STAT_FLAGS = 12'hf62;
   localparam logic [ADDR_W-1:0] OFS_ERR_FLAGS  = 12'hf63;

   // ***********************************************************
   // Field masks and reset values
   // ***********************************************************
   localparam logic [7:0] STAT_EN_MASK  = 8'h7f;
   localparam logic [7:0] STAT_EVT_MASK = 8'h7d;
   localparam logic [7:0] ERR_MASK      = 8'h9f;
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int unsigned TURNAROUND_BIT_TIMES = 16;
   localparam int unsigned BYTE_BITS_LOG2       = 3;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef struct packed {
      logic       unused7;
      logic       frame_start;
      logic       stall_sent;
      logic       idle_detect;
      logic       transaction_done;
      logic       bus_activity;
      logic       error_summary;
      logic       bus_reset;
   } uee_stat_t;

   typedef struct packed {
      logic       stuffing_error_flag;
      logic [1:0] unused6_5;
      logic       turnaround_timeout_flag;
      logic       partial_byte_flag;
      logic       data_check_fail_flag;
      logic       token_check_fail_flag;
      logic       packet_id_fail_flag;
   } uee_err_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } uee_bus_req_t;

endpackage : uee_pkg

// ---- verilog/uee_irq_ctrl.sv ----
// USB status/error interrupt gating, error flags and register port
//
// Behaviour
// R1 - Status enable bits only gate flags toward the processor interrupt.
// R2 - Status flags set on their condition even when not enabled.
// R3 - Enables bit6..0: frame start, stall, idle, done, activity, error, reset.
// R4 - Enable bit 7 and error flag bits 6:5 unimplemented, read zero.
// R5 - Error summary is OR of error flags each gated by its enable.
// R6 - Every error source has its own enable bit.
// R7 - Error flag sets in the cycle the error is detected.
// R8 - Error flag holds until software writes zero to that bit.
// R9 - Error bit 7 sets on bit stuffing violation.
// R10 - Error bit 4 sets after more than 16 idle bit times past EOP.
// R11 - Error bit 3 sets when data field is not whole bytes.
// R12 - Error bit 2 sets on data CRC16 failure, unchanged on pass.
// R13 - Token with bad CRC5 is rejected and error bit 1 set.
// R14 - Error bit 0 sets on failed packet identifier check.
// R15 - Enabled status flags OR into one USB interrupt request.
// R16 - Only enabled errors drive summary; summary is read-only.
// R17 - All enables and error flags reset to zero.
// R18 - Detection in the clearing cycle wins; flag stays set.
`timescale 1ns/1ps
`default_nettype none

module uee_irq_ctrl
   import uee_pkg::*;
#(
   parameter int unsigned DATA_CNT_W = 11
)
(
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [7:0]        reg_rdata_o,
   // Status events from the serial interface engine
   input  wire uee_stat_t         stat_evt_i,
   // Error events from the serial interface engine
   input  wire logic              stuff_err_i,
   input  wire logic              data_crc_fail_i,
   input  wire logic              token_crc_fail_i,
   input  wire logic              pid_fail_i,
   // Packet timing from the serial interface engine
   input  wire logic              bit_tick_i,
   input  wire logic              eop_i,
   input  wire logic              bus_idle_i,
   input  wire logic              data_end_i,
   input  wire logic [DATA_CNT_W-1:0] data_bits_i,
   // Results
   output logic                   token_reject_o,
   output logic                   error_summary_flag_o,
   output logic                   usb_irq_request_o
);

   // ***********************************************************
   // Elaboration checks
   // ***********************************************************
   if (DATA_CNT_W <= BYTE_BITS_LOG2)
   begin : g_bad_cnt_w
      $error("DATA_CNT_W must exceed the byte residue width");
   end

   // ***********************************************************
   // Local types and constants
   // ***********************************************************
   localparam int unsigned TO_CNT_W = $clog2(TURNAROUND_BIT_TIMES + 2);
   localparam logic [TO_CNT_W-1:0] TO_LIMIT =
      TO_CNT_W'(TURNAROUND_BIT_TIMES + 1);
   localparam logic [TO_CNT_W-1:0] TO_ZERO = '0;

   typedef struct packed {
      uee_err_t              err_flags;
      logic [7:0]            err_en;
      logic [7:0]            stat_en;
      uee_stat_t             stat_flags;
      logic [7:0]            rdata;
      logic                  to_armed;
      logic [TO_CNT_W-1:0]   to_cnt;
      logic                  token_reject;
   } uee_state_t;

   localparam uee_state_t STATE_RESET = '{
      err_flags    : uee_err_t'(REG_RESET),
      err_en       : REG_RESET,
      stat_en      : REG_RESET,
      stat_flags   : uee_stat_t'(REG_RESET),
      rdata        : REG_RESET,
      to_armed     : 1'b0,
      to_cnt       : TO_ZERO,
      token_reject : 1'b0
   };

   // ***********************************************************
   // Functions
   // ***********************************************************
   // Sticky update: a set in the same cycle wins over the clear
   function automatic logic [7:0] sticky
   (
      input logic [7:0] old_v,
      input logic [7:0] clr_v,
      input logic [7:0] set_v,
      input logic [7:0] mask_v
   );
      sticky = ((old_v & ~clr_v) | set_v) & mask_v;
   endfunction : sticky

   function automatic logic any_gated
   (
      input logic [7:0] flags_v,
      input logic [7:0] en_v
   );
      any_gated = |(flags_v & en_v);
   endfunction : any_gated

   // ***********************************************************
   // State
   // ***********************************************************
   uee_state_t   s_q;
   uee_state_t   s_d;
   uee_bus_req_t req;
   uee_err_t     err_set;
   logic [7:0]   err_clr;
   logic [7:0]   stat_clr;
   logic [7:0]   stat_set;
   logic         err_summary;
   logic         to_expire;
   logic         partial_byte;

   assign req = '{
      addr  : reg_addr_i,
      wdata : reg_wdata_i,
      wr    : reg_wr_i,
      rd    : reg_rd_i
   };

   // ***********************************************************
   // Error summary and interrupt request
   // ***********************************************************
   // Summary is live, not stored, so software cannot set or clear it
   assign err_summary =
      any_gated(s_q.err_flags, s_q.err_en & ERR_MASK); // [R5] [R6] [R16]

   // ***********************************************************
   // Error detection
   // ***********************************************************
   // Turnaround timer expires on the tick that passes the limit
   assign to_expire = s_q.to_armed && bus_idle_i && bit_tick_i &&
                      (s_q.to_cnt == TO_LIMIT - TO_CNT_W'(1)); // [R10]

   // Data bit count that is not a multiple of eight
   assign partial_byte = data_end_i &&
      (|data_bits_i[BYTE_BITS_LOG2-1:0]); // [R11]

   always_comb
   begin
      err_set = uee_err_t'(REG_RESET);
      err_set.stuffing_error_flag     = stuff_err_i;      // [R9]
      err_set.turnaround_timeout_flag = to_expire;        // [R10]
      err_set.partial_byte_flag       = partial_byte;     // [R11]
      err_set.data_check_fail_flag    = data_crc_fail_i;  // [R12]
      err_set.token_check_fail_flag   = token_crc_fail_i; // [R13]
      err_set.packet_id_fail_flag     = pid_fail_i;       // [R14]
   end

   // ***********************************************************
   // Software clears
   // ***********************************************************
   always_comb
   begin
      err_clr  = REG_RESET;
      stat_clr = REG_RESET;
      if (req.wr && req.addr == OFS_ERR_FLAGS)
      begin
         // Writing a zero clears, writing a one leaves the bit alone
         err_clr = ~req.wdata; // [R8]
      end
      if (req.wr && req.addr == OFS_STAT_CLR)
      begin
         stat_clr = req.wdata;
      end
   end

   assign stat_set = 8'(stat_evt_i) & STAT_EVT_MASK; // [R2]

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb
   begin
      s_d = s_q;

      // Error flags set the same cycle as detection, enable or not
      s_d.err_flags = uee_err_t'(sticky(8'(s_q.err_flags), err_clr,
         8'(err_set), ERR_MASK)); // [R7] [R8] [R18] [R4]

      // Status flags latch regardless of their enable
      s_d.stat_flags = uee_stat_t'(sticky(8'(s_q.stat_flags),
         stat_clr, stat_set, STAT_EVT_MASK)); // [R2] [R18]

      // Enable registers
      if (req.wr && req.addr == OFS_STAT_EN)
      begin
         s_d.stat_en = req.wdata & STAT_EN_MASK; // [R3] [R4]
      end
      if (req.wr && req.addr == OFS_ERR_EN)
      begin
         s_d.err_en = req.wdata & ERR_MASK; // [R6] [R4]
      end

      // Bad token CRC rejects the token, one cycle pulse
      s_d.token_reject = token_crc_fail_i; // [R13]

      // Turnaround timer: arm at end of packet, stop on bus activity
      if (eop_i)
      begin
         s_d.to_armed = 1'b1;
         s_d.to_cnt   = TO_ZERO;
      end
      else if (!bus_idle_i || to_expire)
      begin
         s_d.to_armed = 1'b0;
         s_d.to_cnt   = TO_ZERO;
      end
      else if (s_q.to_armed && bit_tick_i)
      begin
         s_d.to_cnt = s_q.to_cnt + TO_CNT_W'(1); // [R10]
      end

      // Read data stand for one cycle after the read strobe
      s_d.rdata = READ_UNMAPPED;
      if (req.rd)
      begin
         unique case (req.addr)
            OFS_STAT_EN:
            begin
               s_d.rdata = s_q.stat_en & STAT_EN_MASK; // [R4]
            end
            OFS_ERR_EN:
            begin
               s_d.rdata = s_q.err_en & ERR_MASK;
            end
            OFS_STAT_FLAGS:
            begin
               s_d.rdata = 8'(s_q.stat_flags) & STAT_EVT_MASK;
               s_d.rdata[1] = err_summary; // [R16]
            end
            OFS_ERR_FLAGS:
            begin
               s_d.rdata = 8'(s_q.err_flags) & ERR_MASK; // [R4]
            end
            default:
            begin
               s_d.rdata = READ_UNMAPPED;
            end
         endcase
      end
   end

   // ***********************************************************
   // Registers
   // ***********************************************************
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s_q <= STATE_RESET; // [R17]
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   logic [7:0] stat_view;

   always_comb
   begin
      stat_view    = 8'(s_q.stat_flags) & STAT_EVT_MASK;
      stat_view[1] = err_summary;
   end

   assign reg_rdata_o          = s_q.rdata;
   assign token_reject_o       = s_q.token_reject;
   assign error_summary_flag_o = err_summary; // [R16]
   // Status enable bits act only here, on the path to the processor
   assign usb_irq_request_o =
      any_gated(stat_view, s_q.stat_en & STAT_EN_MASK); // [R1] [R15]

endmodule : uee_irq_ctrl

`default_nettype wire

// ---- test/uee_irq_chk.sv ----
// Port assertions for the USB interrupt gate
`timescale 1ns/1ps
`default_nettype none
module uee_irq_chk
   import uee_pkg::*;
(
   input wire logic              ref_clk_i,
   input wire logic              rstn_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0]        reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic [7:0]        reg_rdata_o,
   input wire logic              stuff_err_i,
   input wire logic              data_crc_fail_i,
   input wire logic              token_crc_fail_i,
   input wire logic              pid_fail_i,
   input wire logic              data_end_i,
   input wire logic              bit_tick_i,
   input wire logic              token_reject_o,
   input wire logic              error_summary_flag_o,
   input wire logic              usb_irq_request_o
);
   wire logic rd_err = reg_rd_i && reg_addr_i == OFS_ERR_FLAGS;
   wire logic wr_err = reg_wr_i && reg_addr_i == OFS_ERR_FLAGS;
   wire logic any_ev = stuff_err_i || data_crc_fail_i || token_crc_fail_i
                       || pid_fail_i || data_end_i || bit_tick_i;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_tok; token_crc_fail_i |=> token_reject_o; endproperty
   a_tok: assert property (p_tok) else $error("token not rejected");
   property p_gap; rd_err |=> reg_rdata_o[6:5] == 2'b00; endproperty
   a_gap: assert property (p_gap) else $error("error gap bits set");
   property p_en7;
      reg_rd_i && reg_addr_i == OFS_STAT_EN |=> !reg_rdata_o[7];
   endproperty
   a_en7: assert property (p_en7) else $error("enable bit 7 set");
   property p_stuff; stuff_err_i ##1 !reg_wr_i ##1 rd_err |=> reg_rdata_o[7];
   endproperty
   a_stuff: assert property (p_stuff) else $error("stuff flag lost");
   property p_win;
      pid_fail_i && wr_err && reg_wdata_i == 8'h00 ##1 !reg_wr_i ##1 rd_err
      |=> reg_rdata_o[0];
   endproperty
   a_win: assert property (p_win) else $error("clear beat detection");
   property p_clr;
      wr_err && reg_wdata_i == 8'h00 && !any_ev |=> !error_summary_flag_o;
   endproperty
   a_clr: assert property (p_clr) else $error("summary after clear");
   property p_irq;
      reg_wr_i && reg_addr_i == OFS_STAT_EN && reg_wdata_i == 8'h00
      |=> !usb_irq_request_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq while masked");
   property p_rst;
      $rose(rstn_i) |-> !usb_irq_request_o && !error_summary_flag_o;
   endproperty
   a_rst: assert property (p_rst) else $error("flag after reset");
   c_stuff: cover property (stuff_err_i);
   c_win: cover property (pid_fail_i && wr_err);
   c_irq: cover property (usb_irq_request_o);
endmodule : uee_irq_chk
bind uee_irq_ctrl uee_irq_chk chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pid_fail_i(pid_fail_i),
   .stuff_err_i(stuff_err_i), .data_crc_fail_i(data_crc_fail_i),
   .token_crc_fail_i(token_crc_fail_i), .data_end_i(data_end_i),
   .bit_tick_i(bit_tick_i), .token_reject_o(token_reject_o),
   .error_summary_flag_o(error_summary_flag_o),
   .usb_irq_request_o(usb_irq_request_o));
`default_nettype wire

// ---- test/uee_sie_model.sv ----
// Behavioural serial interface engine driving the gate's event inputs
`timescale 1ns/1ps
`default_nettype none
module uee_sie_model
   import uee_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [2:0]  op_i,
   input  wire logic [10:0] arg_i,
   output var  logic [3:0]  err_o = 4'h0,
   output var  uee_stat_t   stat_o = '0,
   output var  logic        tick_o = 1'b0,
   output var  logic        eop_o = 1'b0,
   output var  logic        idle_o = 1'b0,
   output var  logic        dend_o = 1'b0,
   output var  logic [10:0] bits_o = 11'h0
);
   logic [5:0] n_q = 6'h0;
   always @(posedge clk_i)
   begin
      err_o  <= (go_i && !op_i[2]) ? 4'h1 << op_i[1:0] : 4'h0;
      dend_o <= go_i && op_i == 3'd4;
      // Count is meaningless outside the end pulse, so it keeps moving
      bits_o <= (go_i && op_i == 3'd4) ? arg_i : ~bits_o;
      stat_o <= (go_i && op_i == 3'd6) ? uee_stat_t'(arg_i[7:0]) : '0;
      eop_o  <= go_i && op_i == 3'd5;
      // Bit ticks run only during the idle span after end of packet
      tick_o <= (n_q != 6'h0) && !tick_o;
      idle_o <= n_q != 6'h0;
      if (go_i && op_i == 3'd5)
         n_q <= arg_i[5:0];
      else
         n_q <= n_q - {5'h0, tick_o};
   end
endmodule : uee_sie_model
`default_nettype wire

// ---- test/test_usb_irq_enable_error_status.sv ----
// Self-checking bench for the USB interrupt gate
`timescale 1ns/1ps
`default_nettype none
module test_usb_irq_enable_error_status
   import uee_pkg::*;
();
   typedef struct {logic [ADDR_W-1:0] a; logic [7:0] w, e;} uee_row_t;
   logic ref_clk = 1'b0;
   logic rstn, wr_s, rd_s, go, tick, eop, idle, dend, rej, sum, irq;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        wd, rdata;
   logic [2:0]        op;
   logic [10:0]       arg, bits;
   logic [3:0]        err;
   uee_stat_t         stat;
   int n_errors = 0;
   int checks_done = 0;
   logic [7:0] em [4] = '{8'h80, 8'h04, 8'h02, 8'h01};
   uee_row_t rows [6] = '{'{OFS_STAT_EN, 8'hff, 8'h7f},
      '{OFS_ERR_EN, 8'hff, 8'h9f}, '{OFS_STAT_CLR, 8'hff, 8'h00},
      '{12'hf00, 8'hff, 8'h00}, '{OFS_STAT_EN, 8'h02, 8'h02},
      '{OFS_ERR_EN, 8'h9f, 8'h9f}};
   always #25 ref_clk = ~ref_clk;
   uee_sie_model sie (.clk_i(ref_clk), .go_i(go), .op_i(op), .arg_i(arg),
      .err_o(err), .stat_o(stat), .tick_o(tick), .eop_o(eop),
      .idle_o(idle), .dend_o(dend), .bits_o(bits));
   uee_irq_ctrl uut (.ref_clk_i(ref_clk), .rstn_i(rstn), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .stat_evt_i(stat), .stuff_err_i(err[0]), .data_crc_fail_i(err[1]),
      .token_crc_fail_i(err[2]), .pid_fail_i(err[3]), .bit_tick_i(tick),
      .eop_i(eop), .bus_idle_i(idle), .data_end_i(dend), .data_bits_i(bits),
      .token_reject_o(rej), .error_summary_flag_o(sum),
      .usb_irq_request_o(irq));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_s <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge ref_clk);
      wr_s <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd
   task automatic ev(input logic [2:0] o, input logic [10:0] a, input int w);
      @(posedge ref_clk);
      go <= 1'b1;
      op <= o;
      arg <= a;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (w) @(posedge ref_clk);
   endtask : ev
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   // ***********************************************************
   // Tests
   // ***********************************************************
   initial
   begin
      rstn = 1'b0;
      {wr_s, rd_s, go, addr, wd, op, arg} = '0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(OFS_STAT_EN, 8'h00);
      rd(OFS_ERR_EN, 8'h00);
      rd(OFS_ERR_FLAGS, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e);
      end
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         ev(3'(i), 11'h0, 1);
         #1 chk({7'h0, rej}, {7'h0, i == 2});
         rd(OFS_ERR_FLAGS, em[i]);
         chk({6'h0, sum, irq}, 8'h03);
         wr(OFS_ERR_FLAGS, ~em[i]);
         rd(OFS_ERR_FLAGS, 8'h00);
         chk({6'h0, sum, irq}, 8'h00);
      end
      wr(OFS_ERR_EN, 8'h1f);
      ev(3'd0, 11'h0, 1);
      rd(OFS_ERR_FLAGS, 8'h80);
      chk({6'h0, sum, irq}, 8'h00);
      wr(OFS_ERR_FLAGS, 8'hff);
      rd(OFS_ERR_FLAGS, 8'h80);
      wr(OFS_ERR_FLAGS, 8'h7f);
      ev(3'd4, 11'd13, 1);
      rd(OFS_ERR_FLAGS, 8'h08);
      wr(OFS_ERR_FLAGS, 8'h00);
      ev(3'd4, 11'd16, 1);
      rd(OFS_ERR_FLAGS, 8'h00);
      ev(3'd5, 11'd16, 40);
      rd(OFS_ERR_FLAGS, 8'h00);
      ev(3'd5, 11'd17, 40);
      rd(OFS_ERR_FLAGS, 8'h10);
      chk({7'h0, sum}, 8'h01);
      ev(3'd3, 11'h0, 0);
      wr_s <= 1'b1;
      addr <= OFS_ERR_FLAGS;
      wd <= 8'h00;
      @(posedge ref_clk);
      wr_s <= 1'b0;
      rd(OFS_ERR_FLAGS, 8'h01);
      wr(OFS_ERR_FLAGS, 8'h00);
      $display("test errors done");
      wr(OFS_STAT_EN, 8'h00);
      ev(3'd6, 11'h7d, 1);
      rd(OFS_STAT_FLAGS, 8'h7d);
      chk({7'h0, irq}, 8'h00);
      wr(OFS_STAT_EN, 8'h40);
      chk({7'h0, irq}, 8'h01);
      wr(OFS_STAT_CLR, 8'h7d);
      chk({7'h0, irq}, 8'h00);
      rd(OFS_STAT_FLAGS, 8'h00);
      $display("test status done");
      print_verdict();
   end
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      print_verdict();
   end
endmodule : test_usb_irq_enable_error_status
`default_nettype wire
